// ---- mcsu_pkg.sv ----
// Constants, register map and field layout of the memory chip select unit.
// Assumes nothing: shared by the top module and the decoder.
package mcsu_pkg;
    // Register offsets on the plain register port
    localparam logic [7:0] LOW_CFG_OFS = 8'ha2; // Low region config
    localparam logic [7:0] MID_BASE_OFS = 8'ha6; // Midrange base
    localparam logic [7:0] AUX_SEL_OFS = 8'ha8; // Shared aux select
    localparam logic [7:0] SYS_CFG_OFS = 8'hf0; // System config
    localparam int ADDR_W = 20; // Memory address width
    localparam int REG_W = 16; // Register width
    // Low region config fields
    localparam int LOW_UB_LSB = 12; // Upper bound field, 3 bits
    localparam int ADDR_DIS_BIT = 7; // Address drive disable
    localparam logic [15:0] LOW_RST = 16'h0000; // Drive disable reads 0
    // Midrange base fields
    localparam int MID_BASE_LSB = 9; // Base A19..A13, 7 bits
    localparam int MID_ADDR_LSB = 13; // Lowest address bit of the base
    // Shared aux select fields
    localparam int MID_SIZE_LSB = 8; // One-hot block size, 7 bits
    localparam int PIN_FUNC_BIT = 7; // 1 chip selects, 0 address outs
    localparam int MEM_IO_BIT = 6; // 1 memory cycles, 0 I/O cycles
    localparam int READY_BIT = 2; // 0 external ready needed
    localparam int WAIT_LSB = 0; // Wait count, 2 bits
    // System config fields
    localparam int SINGLE_MID_BIT = 14; // Single midrange select mode
    // Peripheral select decode
    localparam int PER_BASE_LSB = 11; // Base covers A19..A11
    localparam logic [2:0] PER_FIVE_SLOT = 3'h5; // 256-byte slot five
    localparam logic [2:0] PER_SIX_SLOT = 3'h6; // 256-byte slot six
    localparam int PER_SLOT_LSB = 8; // Slot index A10..A8
    // Synchroniser and strap capture
    localparam logic [1:0] STRAP_SETTLE = 2'h3; // Cycles before capture
    // Bus cycle states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, // No cycle
        ST_ADDR = 2'b01, // Address phase
        ST_DATA = 2'b10 // Data phase with waits
    } mcsu_state_type;
endpackage

// ---- mcsu_sync3.sv ----
// Three-stage input synchroniser with agreement filter.
// Assumes an asynchronous pin input and one clock domain.
`timescale 1ns/1ps
module mcsu_sync3 (
    input wire logic clk_in, // Clock
    input wire logic rst_n_in, // Async reset, active low
    input wire logic ce_in, // Clock enable
    input wire logic pin_in, // Raw pin level
    output logic level_out // Filtered level
);
    logic s1_ff; // First stage, read only by second
    logic s2_ff; // Second stage
    logic s3_ff; // Third stage
    logic level_ff; // Accepted level

    // Shift chain, left unreset so a level held through reset
    // has already settled when reset is released
    always_ff @(posedge clk_in) begin
        if (ce_in) begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // Accept a change once stages two and three agree
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            level_ff <= 1'b1; // Idle level of ready and strap
        end else if (ce_in && (s2_ff == s3_ff)) begin
            level_ff <= s3_ff;
        end
    end

    assign level_out = level_ff;
endmodule // mcsu_sync3

// ---- mcsu_region_decode.sv ----
// Combinational address decoder for low, midrange and peripheral regions.
// Assumes configuration registers and a stable latched bus address.
`timescale 1ns/1ps
module mcsu_region_decode (
    input wire logic [19:0] addr_in, // Bus address
    input wire logic mem_cycle_in, // 1 memory cycle, 0 I/O cycle
    input wire logic [2:0] low_ub_in, // Low upper bound field
    input wire logic [6:0] mid_base_in, // Midrange base A19..A13
    input wire logic [6:0] mid_size_in, // One-hot midrange size
    input wire logic single_mid_in, // Single midrange select mode
    input wire logic per_mem_in, // Peripheral space select
    input wire logic [8:0] per_base_in, // Peripheral base A19..A11
    output logic low_hit_out, // Low region hit
    output logic [3:0] mid_hit_out, // Midrange selects, active high
    output logic [1:0] per_hit_out // Slot six, slot five hits
);
    // Compare mask over A19..A13: bits at or above the block size
    function automatic logic [6:0] mid_mask(input logic [6:0] size);
        logic [6:0] m;
        m = 7'h00;
        for (int i = 0; i < 7; i++) begin
            m[i] = |(size & 7'((2 << i) - 1));
        end
        return m;
    endfunction

    // Quarter of the block addressed, two bits below the block size
    function automatic logic [1:0] mid_quarter(input logic [19:0] a,
                                               input logic [6:0] size);
        logic [1:0] q;
        q = 2'h0;
        for (int k = 0; k < 7; k++) begin
            if (size[k]) begin
                q = a[11 + k +: 2];
            end
        end
        return q;
    endfunction

    logic mid_block; // Address inside the midrange block
    logic [1:0] quarter; // Quarter index
    logic [6:0] mask; // Compare mask

    always_comb begin
        // low region from zero up to its programmed top
        low_hit_out = mem_cycle_in && !addr_in[19] &&
                      ((addr_in[18:16] & ~low_ub_in) == 3'h0);
        mask = mid_mask(mid_size_in);
        quarter = mid_quarter(addr_in, mid_size_in);
        // base bits A12..A0 taken as zero
        mid_block = mem_cycle_in &&
            (((addr_in[19:13] ^ mid_base_in) & mask) == 7'h00);
        mid_hit_out = 4'h0;
        if (mid_block) begin
            mid_hit_out[quarter] = 1'b1;
            if (single_mid_in) begin
                mid_hit_out[0] = 1'b1;
            end
        end
        per_hit_out = 2'h0;
        if ((mem_cycle_in == per_mem_in) &&
            (addr_in[19:11] == per_base_in)) begin
            per_hit_out[0] = (addr_in[10:8] == mcsu_pkg::PER_FIVE_SLOT);
            per_hit_out[1] = (addr_in[10:8] == mcsu_pkg::PER_SIX_SLOT);
        end
    end
endmodule // mcsu_region_decode

// ---- mcsu_chip_select.sv ----
// Memory chip select unit: register port, decode and bus cycle sequencing.
// Assumes one bus cycle request at a time, a register master that never
// waits, and the peripheral base supplied by a neighbouring block.
`timescale 1ns/1ps
module mcsu_chip_select (
    input wire logic clk_in, // 40 MHz clock
    input wire logic rst_n_in, // Async reset, active low
    input wire logic ce_in, // Clock enable, freezes all state
    input wire logic [7:0] reg_addr_in, // Register address
    input wire logic [15:0] reg_wdata_in, // Register write data
    input wire logic reg_wr_in, // Register write strobe
    input wire logic reg_rd_in, // Register read strobe
    output logic [15:0] reg_rdata_out, // Read data, cycle after strobe
    input wire logic cycle_start_in, // Bus cycle request pulse
    input wire logic [19:0] addr_in, // Nonmultiplexed address
    input wire logic mem_cycle_in, // 1 memory, 0 I/O cycle
    input wire logic [8:0] per_base_in, // Peripheral base A19..A11
    input wire logic per_base_set_in, // Peripheral base programmed
    input wire logic ready_pin_in, // External ready pin
    input wire logic addr_strap_pin_in, // Address enable strap pin
    output logic low_region_select_n_out, // Low region select
    output logic [3:0] mid_region_selects_n_out, // Midrange selects
    output logic periph_select_five_out, // Select or latched A1
    output logic periph_select_six_out, // Select or latched A2
    output logic addr_drive_en_out, // Address/data driven now
    output logic busy_out, // Bus cycle in progress
    output logic cycle_done_out // Bus cycle ends, one pulse
);
    // Configuration storage
    logic [15:0] low_cfg_ff; // Low region config
    logic [15:0] mid_base_ff; // Midrange base
    logic [15:0] aux_sel_ff; // Shared aux select
    logic single_mid_ff; // Single midrange select mode
    logic low_active_ff; // Low select enabled
    logic mid_active_ff; // Midrange base written
    logic aux_written_ff; // Aux select written
    logic per_addr_active_ff; // Aux accessed, address mode armed
    // Bus cycle state
    mcsu_pkg::mcsu_state_type state_ff; // Cycle state
    mcsu_pkg::mcsu_state_type nxt_state; // Next cycle state
    logic [1:0] wait_ff; // Remaining wait states
    logic need_ready_ff; // External ready required
    logic low_sel_ff; // Low select, active high
    logic [3:0] mid_pend_ff; // Midrange hits awaiting data phase
    logic [3:0] mid_sel_ff; // Midrange selects, active high
    logic [1:0] per_sel_ff; // Peripheral selects, active high
    logic [1:0] lat_a_ff; // Latched A2, A1
    logic drive_ff; // Address drive enable
    logic done_ff; // Cycle end pulse
    // Strap capture
    logic [1:0] settle_ff; // Cycles since reset release
    logic strap_forced_ff; // Strap seen low: always drive
    // Decoder results and helpers
    logic low_hit; // Low region hit
    logic [3:0] mid_hit; // Midrange hits
    logic [1:0] per_hit; // Peripheral slot hits
    logic ready_sync; // Filtered ready
    logic strap_sync; // Filtered strap
    logic finish; // Data phase ends this cycle
    logic wr_low; // Write to low config
    logic wr_mid; // Write to midrange base
    logic wr_aux; // Write to aux select
    logic wr_sys; // Write to system config
    logic per_cs_mode; // Upper selects act as chip selects

    // Address and space decode
    mcsu_region_decode u_decode (
        .addr_in(addr_in),
        .mem_cycle_in(mem_cycle_in),
        .low_ub_in(low_cfg_ff[mcsu_pkg::LOW_UB_LSB +: 3]),
        .mid_base_in(mid_base_ff[mcsu_pkg::MID_BASE_LSB +: 7]),
        .mid_size_in(aux_sel_ff[mcsu_pkg::MID_SIZE_LSB +: 7]),
        .single_mid_in(single_mid_ff),
        .per_mem_in(aux_sel_ff[mcsu_pkg::MEM_IO_BIT]),
        .per_base_in(per_base_in),
        .low_hit_out(low_hit),
        .mid_hit_out(mid_hit),
        .per_hit_out(per_hit)
    );

    // External ready pin
    mcsu_sync3 u_ready_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .pin_in(ready_pin_in),
        .level_out(ready_sync)
    );

    // Address enable strap pin
    mcsu_sync3 u_strap_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .pin_in(addr_strap_pin_in),
        .level_out(strap_sync)
    );

    // Write decode
    assign wr_low = reg_wr_in && (reg_addr_in == mcsu_pkg::LOW_CFG_OFS);
    assign wr_mid = reg_wr_in && (reg_addr_in == mcsu_pkg::MID_BASE_OFS);
    assign wr_aux = reg_wr_in && (reg_addr_in == mcsu_pkg::AUX_SEL_OFS);
    assign wr_sys = reg_wr_in && (reg_addr_in == mcsu_pkg::SYS_CFG_OFS);
    assign per_cs_mode = aux_sel_ff[mcsu_pkg::PIN_FUNC_BIT];

    // Low region config register
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            low_cfg_ff <= mcsu_pkg::LOW_RST;
            low_active_ff <= 1'b0;
        end else if (ce_in && wr_low) begin
            low_cfg_ff <= reg_wdata_in;
            low_active_ff <= 1'b1;
        end
    end

    // Midrange base register, stored as written
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mid_base_ff <= 16'h0000;
            mid_active_ff <= 1'b0;
        end else if (ce_in && wr_mid) begin
            mid_base_ff <= reg_wdata_in;
            mid_active_ff <= 1'b1;
        end
    end

    // Shared aux select register
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            aux_sel_ff <= 16'h0000;
            aux_written_ff <= 1'b0;
        end else if (ce_in && wr_aux) begin
            aux_sel_ff <= reg_wdata_in;
            aux_written_ff <= 1'b1;
        end
    end

    // Any access to aux arms the address outputs
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            per_addr_active_ff <= 1'b0;
        end else if (ce_in && (reg_wr_in || reg_rd_in) &&
                     (reg_addr_in == mcsu_pkg::AUX_SEL_OFS)) begin
            per_addr_active_ff <= 1'b1;
        end
    end

    // Single midrange select mode bit
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            single_mid_ff <= 1'b0;
        end else if (ce_in && wr_sys) begin
            single_mid_ff <= reg_wdata_in[mcsu_pkg::SINGLE_MID_BIT];
        end
    end

    // Read data, valid only in the cycle after the strobe
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (ce_in) begin
            reg_rdata_out <= 16'h0000;
            if (reg_rd_in) begin
                case (reg_addr_in)
                    mcsu_pkg::LOW_CFG_OFS: reg_rdata_out <= low_cfg_ff;
                    mcsu_pkg::MID_BASE_OFS: reg_rdata_out <= mid_base_ff;
                    mcsu_pkg::AUX_SEL_OFS: reg_rdata_out <= aux_sel_ff;
                    mcsu_pkg::SYS_CFG_OFS: begin
                        reg_rdata_out[mcsu_pkg::SINGLE_MID_BIT] <=
                            single_mid_ff;
                    end
                    default: reg_rdata_out <= 16'h0000; // Unmapped reads zero
                endcase
            end
        end
    end

    // Strap capture a fixed time after reset release
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            settle_ff <= 2'h0;
            strap_forced_ff <= 1'b1; // Drive until strap is known
        end else if (ce_in && (settle_ff != mcsu_pkg::STRAP_SETTLE)) begin
            settle_ff <= settle_ff + 2'h1;
            if (settle_ff == mcsu_pkg::STRAP_SETTLE - 2'h1) begin
                strap_forced_ff <= !strap_sync;
            end
        end
    end

    // Data phase ends once waits expire and ready, if needed, is seen
    assign finish = (state_ff == mcsu_pkg::ST_DATA) && (wait_ff == 2'h0) &&
                    (!need_ready_ff || ready_sync);

    // Cycle state sequencing
    always_comb begin
        case (state_ff)
            mcsu_pkg::ST_IDLE: begin
                nxt_state = cycle_start_in ? mcsu_pkg::ST_ADDR
                                           : mcsu_pkg::ST_IDLE;
            end
            mcsu_pkg::ST_ADDR: nxt_state = mcsu_pkg::ST_DATA;
            mcsu_pkg::ST_DATA: begin
                nxt_state = finish ? mcsu_pkg::ST_IDLE : mcsu_pkg::ST_DATA;
            end
            default: nxt_state = mcsu_pkg::ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_ff <= mcsu_pkg::ST_IDLE;
        end else if (ce_in) begin
            state_ff <= nxt_state;
        end
    end

    // Wait count and ready mode chosen by the region hit
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wait_ff <= 2'h0;
            need_ready_ff <= 1'b0;
        end else if (ce_in) begin
            if (state_ff == mcsu_pkg::ST_IDLE && cycle_start_in) begin
                wait_ff <= 2'h0;
                need_ready_ff <= 1'b0;
                if (low_hit && low_active_ff) begin
                    wait_ff <= low_cfg_ff[mcsu_pkg::WAIT_LSB +: 2];
                    need_ready_ff <= !low_cfg_ff[mcsu_pkg::READY_BIT];
                end else if ((|mid_hit) && mid_active_ff) begin
                    wait_ff <= mid_base_ff[mcsu_pkg::WAIT_LSB +: 2];
                    need_ready_ff <= !mid_base_ff[mcsu_pkg::READY_BIT];
                end else if ((|per_hit) && per_cs_mode && aux_written_ff &&
                             per_base_set_in) begin
                    wait_ff <= aux_sel_ff[mcsu_pkg::WAIT_LSB +: 2];
                    need_ready_ff <= !aux_sel_ff[mcsu_pkg::READY_BIT];
                end
            end else if (state_ff == mcsu_pkg::ST_DATA && wait_ff != 2'h0) begin
                wait_ff <= wait_ff - 2'h1;
            end
        end
    end

    // Low and peripheral selects from the address phase onward
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            low_sel_ff <= 1'b0;
            per_sel_ff <= 2'h0;
            mid_pend_ff <= 4'h0;
            lat_a_ff <= 2'h0;
        end else if (ce_in) begin
            if (state_ff == mcsu_pkg::ST_IDLE && cycle_start_in) begin
                low_sel_ff <= low_hit && low_active_ff;
                mid_pend_ff <= mid_active_ff ? mid_hit : 4'h0;
                per_sel_ff <= (aux_written_ff && per_base_set_in)
                              ? per_hit : 2'h0;
                lat_a_ff <= {addr_in[2], addr_in[1]};
            end else if (finish) begin
                low_sel_ff <= 1'b0;
                per_sel_ff <= 2'h0;
                mid_pend_ff <= 4'h0;
            end
        end
    end

    // Midrange selects start one clock after the low select
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mid_sel_ff <= 4'h0;
        end else if (ce_in) begin
            if (state_ff == mcsu_pkg::ST_ADDR) begin
                mid_sel_ff <= mid_pend_ff;
            end else if (finish) begin
                mid_sel_ff <= 4'h0;
            end
        end
    end

    // Address drive only in the address phase
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            drive_ff <= 1'b0;
        end else if (ce_in) begin
            if (state_ff == mcsu_pkg::ST_IDLE && cycle_start_in) begin
                drive_ff <= strap_forced_ff || !(low_hit && low_active_ff &&
                            low_cfg_ff[mcsu_pkg::ADDR_DIS_BIT]);
            end else begin
                drive_ff <= 1'b0;
            end
        end
    end

    // Cycle end pulse
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            done_ff <= 1'b0;
        end else if (ce_in) begin
            done_ff <= finish;
        end
    end

    // Output pin levels, all registered
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            low_region_select_n_out <= 1'b1;
            mid_region_selects_n_out <= 4'hf;
            periph_select_five_out <= 1'b1;
            periph_select_six_out <= 1'b1;
            addr_drive_en_out <= 1'b0;
            busy_out <= 1'b0;
            cycle_done_out <= 1'b0;
        end else if (ce_in) begin
            low_region_select_n_out <= !low_sel_ff;
            mid_region_selects_n_out <= ~mid_sel_ff;
            if (per_cs_mode) begin
                periph_select_five_out <= !per_sel_ff[0];
                periph_select_six_out <= !per_sel_ff[1];
            end else if (per_addr_active_ff) begin
                periph_select_five_out <= lat_a_ff[0];
                periph_select_six_out <= lat_a_ff[1];
            end else begin
                periph_select_five_out <= 1'b1;
                periph_select_six_out <= 1'b1;
            end
            addr_drive_en_out <= drive_ff;
            busy_out <= (state_ff != mcsu_pkg::ST_IDLE);
            cycle_done_out <= done_ff;
        end
    end
endmodule // mcsu_chip_select

// ---- mcsu_chip_select_properties.sv ----
// Port checker for the memory chip select unit.
// Assumes only the top ports; bound below.
`timescale 1ns/1ps
module mcsu_chip_select_properties (
    input wire logic clk_in, // Clock
    input wire logic rst_n_in, // Reset
    input wire logic reg_rd_in, // Read
    input wire logic [15:0] reg_rdata_out, // Data
    input wire logic low_region_select_n_out, // Low
    input wire logic [3:0] mid_region_selects_n_out, // Mid
    input wire logic periph_select_five_out, // Five
    input wire logic periph_select_six_out, // Six
    input wire logic addr_drive_en_out, // Drive
    input wire logic busy_out, // Busy
    input wire logic cycle_done_out // Done
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // Done pulses as busy drops, for one cycle only
    sequence s_end;
        (cycle_done_out && !busy_out) ##1 !cycle_done_out;
    endsequence
    idle_reset_a: assert property ($rose(rst_n_in) |->
        low_region_select_n_out && periph_select_five_out &&
        periph_select_six_out) else $error("idle");
    rd_quiet_a: assert property (!$past(reg_rd_in) |->
        reg_rdata_out == 16'h0) else $error("stray read data");
    low_start_a: assert property ($fell(low_region_select_n_out) |->
        $rose(busy_out)) else $error("low select early");
    mid_late_a: assert property ($fell(&mid_region_selects_n_out) |->
        $past(busy_out) && !$past(busy_out, 2)) else $error("mid timing");
    drive_once_a: assert property (addr_drive_en_out |->
        $rose(busy_out) ##1 !addr_drive_en_out) else $error("drive");
    end_seq_a: assert property ($fell(busy_out) |-> s_end)
        else $error("no done");
    busy_bound_a: assert property ($rose(busy_out) |->
        ##[2:60] !busy_out) else $error("busy hang");
    done_one_a: assert property (cycle_done_out |=>
        !cycle_done_out) else $error("done too long");
endmodule // mcsu_chip_select_properties
bind mcsu_chip_select mcsu_chip_select_properties u_props (.clk_in,
    .rst_n_in, .reg_rd_in, .reg_rdata_out, .low_region_select_n_out,
    .mid_region_selects_n_out, .periph_select_five_out,
    .periph_select_six_out, .addr_drive_en_out, .busy_out, .cycle_done_out);

// ---- mcsu_mem_model.sv ----
// External memory answering with ready.
// Assumes busy marks a bus cycle.
`timescale 1ns/1ps
module mcsu_mem_model (
    input wire logic clk_in, // Clock
    input wire logic busy_in, // Cycle on
    input wire logic slow_in, // Slow part
    output logic ready_out // Ready
);
    int cnt = 0; // Cycles into access
    initial ready_out = 1'b1;
    // Slow part holds ready low five cycles
    always @(posedge clk_in) begin
        cnt <= busy_in ? cnt + 1 : 0;
        ready_out <= !slow_in || cnt > 4;
    end
endmodule // mcsu_mem_model

// ---- test_memory_chip_select_unit.sv ----
// Self-checking bench for the memory chip select unit.
// Assumes the unit, its checker and the memory model.
`timescale 1ns/1ps
module test_memory_chip_select_unit;
    logic clk_in = 0, rst_n_in = 0, wr = 0, rd = 0, st = 0, mem = 0;
    logic slow = 0, rdy, lo, p5, p6, dr, bsy, done, l2, q5, q6, d2;
    logic [3:0] mid, ms;
    logic [7:0] ra = 8'h0;
    logic [8:0] pb = 9'h002;
    logic [15:0] wd = 16'h0, rdat, v;
    logic [19:0] a = 20'h0;
    logic [7:0] offs[5] = '{8'ha2, 8'ha6, 8'ha8, 8'hf0, 8'h3c};
    int n_mismatch = 0, n_tests = 0, cyc = 0, lat, sz;
    int rm[int]; // Register model
    mcsu_chip_select u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .ce_in(1'b1), .reg_addr_in(ra), .reg_wdata_in(wd), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdat), .cycle_start_in(st),
        .addr_in(a), .mem_cycle_in(mem), .per_base_in(pb),
        .per_base_set_in(1'b1), .ready_pin_in(rdy),
        .addr_strap_pin_in(1'b1), .low_region_select_n_out(lo),
        .mid_region_selects_n_out(mid), .periph_select_five_out(p5),
        .periph_select_six_out(p6), .addr_drive_en_out(dr),
        .busy_out(bsy), .cycle_done_out(done));
    mcsu_mem_model u_mem (.clk_in(clk_in), .busy_in(bsy), .slow_in(slow),
        .ready_out(rdy));
    always #12.5 clk_in = ~clk_in;
    // Hang guard
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            conclude();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, s);
        n_tests++;
        if (e !== s) begin
            $display("MISMATCH %s exp %h got %h", n, e, s);
            n_mismatch++;
        end
    endtask
    task automatic wreg(input logic [7:0] ad, input logic [15:0] d);
        @(posedge clk_in);
        ra <= ad;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
        if (ad == 8'hf0) rm[ad] = d & 16'h4000;
        else if (ad != 8'h3c) rm[ad] = d;
    endtask
    // Read data stands in the cycle after the strobe edge
    task automatic rreg(input logic [7:0] ad);
        @(posedge clk_in);
        ra <= ad;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1 v = rdat;
    endtask
    // One bus cycle; snapshots at output edges two and three
    task automatic bus(input logic [19:0] ad, input logic m);
        @(posedge clk_in);
        a <= ad;
        mem <= m;
        st <= 1'b1;
        @(posedge clk_in);
        st <= 1'b0;
        @(posedge clk_in);
        #1 {l2, q5, q6, d2} = {lo, p5, p6, dr};
        @(posedge clk_in);
        #1 ms = mid;
        lat = 3;
        while (done !== 1'b1 && lat < 90) begin
            @(posedge clk_in);
            #1 lat++;
        end
    endtask
    task automatic conclude();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        void'($urandom(10));
        repeat (16) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rreg(8'ha2);
        chk("da", 1'b0, v[7]);
        rreg(8'hf0);
        chk("single", 1'b0, v[14]);
        bus(20'h00100, 1'b1);
        chk("idle", 3'h7, {l2, q5, q6});
        foreach (offs[j]) begin
            v = 16'($urandom);
            if (j == 1) v = v | 16'h01f8;
            if (j == 2) v = v & 16'h00c7 | 16'h8138;
            wreg(offs[j], v);
            rreg(offs[j]);
            chk("readback", rm.exists(offs[j]) ? rm[offs[j]] : 0, v);
        end
        wreg(8'hf0, 16'h0);
        wreg(8'ha6, 16'h81fc);
        for (int j = 0; j < 4; j++) begin
            sz = 32'h10000 << j;
            wreg(8'ha2, 16'((((1 << j) - 1) << 12) | 4 | j));
            bus(20'(sz - 1), 1'b1);
            chk("low hit", 2'b01, {l2, d2});
            chk("low wait", 4 + j, lat);
            bus(20'(sz), 1'b1);
            chk("low miss", 1'b1, l2);
        end
        wreg(8'ha2, 16'h3084);
        bus(20'h00100, 1'b1);
        chk("da on", 1'b0, d2);
        slow <= 1'b1;
        wreg(8'ha2, 16'h3000);
        bus(20'h00100, 1'b1);
        chk("ready", 1'b1, lat > 9);
        slow <= 1'b0;
        wreg(8'ha2, 16'h3004);
        for (int k = 0; k < 7; k++) begin
            sz = 32'h2000 << k;
            wreg(8'ha8, 16'h80bc | 16'(32'h100 << k));
            bus(20'(32'h80000 + k % 4 * sz / 4 + $urandom_range(sz / 4 - 1)),
                1'b1);
            chk("mid", 4'(~(4'h1 << k % 4)), ms);
            chk("mid wait", 4, lat);
            bus(20'(32'h80000 + sz), 1'b1);
            chk("mid miss", 4'hf, ms);
        end
        wreg(8'hf0, 16'h4000);
        bus(20'ha0000, 1'b1);
        chk("single", 4'hc, ms);
        wreg(8'hf0, 16'h0);
        wreg(8'ha8, 16'h81be);
        bus(20'h01500, 1'b0);
        chk("five", 2'b01, {q5, q6});
        chk("per wait", 6, lat);
        bus(20'h01600, 1'b0);
        chk("six", 2'b10, {q5, q6});
        bus(20'h01500, 1'b1);
        chk("mem skip", 2'b11, {q5, q6});
        pb <= 9'h0c0;
        wreg(8'ha8, 16'h81fc);
        bus(20'h60500, 1'b1);
        chk("mem five", 2'b01, {q5, q6});
        wreg(8'ha8, 16'h813c);
        bus(20'h00004, 1'b1);
        chk("addr", 2'b01, {q5, q6});
        bus(20'h00002, 1'b1);
        chk("addr", 2'b10, {q5, q6});
        conclude();
    end
endmodule // test_memory_chip_select_unit
